/* dv/irq_host_input.sv */
// Purpose: host side of the two interrupt request lines
// Assumes: each line carries a pull-up at the host input
// Notes:   a request is seen while the line sits at its active level
`timescale 1ns/10ps
`default_nettype none

module irq_host_input (
  input  wire logic a_out_i,
  input  wire logic a_oe_i,
  input  wire logic b_out_i,
  input  wire logic b_oe_i,
  input  wire logic pol_a_i,
  input  wire logic pol_b_i,
  output logic      line_a_o,
  output logic      line_b_o,
  output logic      req_a_o,
  output logic      req_b_o
);
  // a released line is pulled high, never left at its last value
  assign line_a_o = a_oe_i ? a_out_i : 1'b1;
  assign line_b_o = b_oe_i ? b_out_i : 1'b1;
  assign req_a_o  = (line_a_o == pol_a_i);
  assign req_b_o  = (line_b_o == pol_b_i);
endmodule

`default_nettype wire

/* dv/tb_host_irq_pin_output.sv */
// Purpose: self-checking bench of the host interrupt pin stage
// Assumes: host input model with pull-ups on both lines
// Notes:   sweeps all 32 pin control settings, idle and pending
`timescale 1ns/10ps
`default_nettype none

module tb_host_irq_pin_output;
  logic                   sys_clk_i;
  logic                   rst_i;
  irq_pin_pkg::axil_req_t bus_req;
  irq_pin_pkg::axil_rsp_t bus_rsp;
  logic                   write_err, read_err, irq;
  logic                   a_out, a_oe, b_out, b_oe, line_a, line_b, req_a, req_b;
  logic [4:0]             ctrl;
  logic [31:0]            rdat;
  logic [1:0]             resp;
  int                     failures;
  int                     cmp_count;

  always #2.5 sys_clk_i = ~sys_clk_i;

  irq_pin_ctrl u_irq_pin_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req),
    .bus_rsp_o(bus_rsp), .write_err_i(write_err), .read_err_i(read_err), .irq_o(irq),
    .irq_out_a_o(a_out), .irq_out_a_oe_o(a_oe), .irq_out_b_o(b_out), .irq_out_b_oe_o(b_oe));

  irq_host_input u_irq_host_input (.a_out_i(a_out), .a_oe_i(a_oe), .b_out_i(b_out),
    .b_oe_i(b_oe), .pol_a_i(ctrl[0]), .pol_b_i(ctrl[1]), .line_a_o(line_a),
    .line_b_o(line_b), .req_a_o(req_a), .req_b_o(req_b));

  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr  <= a;
    bus_req.wvalid  <= 1'b1;
    bus_req.wdata   <= d;
    bus_req.bready  <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge sys_clk_i);
      if (bus_rsp.awready)
        bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready)
        bus_req.wvalid <= 1'b0;
      if (bus_rsp.bvalid)
        break;
    end
    resp = bus_rsp.bresp;
    chk(bus_rsp.bvalid, 1'b1);
    bus_req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    bus_req.arvalid <= 1'b1;
    bus_req.araddr  <= a;
    bus_req.rready  <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge sys_clk_i);
      if (bus_rsp.arready)
        bus_req.arvalid <= 1'b0;
      if (bus_rsp.rvalid)
        break;
    end
    rdat = bus_rsp.rdata;
    resp = bus_rsp.rresp;
    chk(bus_rsp.rvalid, 1'b1);
    bus_req.rready <= 1'b0;
  endtask

  task automatic pulse(input logic w, input logic r);
    @(posedge sys_clk_i);
    write_err <= w;
    read_err  <= r;
    @(posedge sys_clk_i);
    write_err <= 1'b0;
    read_err  <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // {oe, level}: level counts only while driven
  function automatic logic [1:0] exp_pin(input logic act, input logic pol, input logic style);
    if (pol)
      return {1'b1, act};
    if (style)
      return {1'b1, !act};
    return {act, 1'b0};
  endfunction

  task automatic check_pins(input logic pend);
    logic act_a;
    act_a = pend & ctrl[4];
    chk(irq, pend);
    chk({a_oe, a_oe & a_out}, exp_pin(act_a, ctrl[0], ctrl[2]));
    chk({b_oe, b_oe & b_out}, exp_pin(pend, ctrl[1], ctrl[3]));
    chk({req_a, req_b}, {act_a, pend});
  endtask

  task automatic scan(input logic pend);
    for (int c = 0; c < 32; c++)
    begin
      ctrl = 5'(c);
      wr(irq_pin_pkg::ADDR_PIN_CTRL, {16'h0000, ctrl, 11'h000});
      settle;
      check_pins(pend);
    end
  endtask

  task automatic test_reset;
    chk({a_oe, b_oe, irq}, 3'h0);
    rd(irq_pin_pkg::ADDR_PIN_CTRL);
    chk(rdat, 32'h0000_0000);
    rd(irq_pin_pkg::ADDR_ENABLE);
    chk(rdat, 32'h0000_0000);
    rd(8'h00);
    chk(resp, irq_pin_pkg::RESP_SLVERR);
  endtask

  task automatic test_mask;
    pulse(1'b0, 1'b1);
    settle;
    rd(irq_pin_pkg::ADDR_STATUS);
    chk(rdat, 32'h0000_0002);
    chk(irq, 1'b0);
    wr(irq_pin_pkg::ADDR_ENABLE, 32'h0000_0002);
    settle;
    chk(irq, 1'b1);
    wr(irq_pin_pkg::ADDR_STATUS, 32'h0000_0002);
    settle;
    chk(irq, 1'b0);
  endtask

  task automatic test_table;
    wr(irq_pin_pkg::ADDR_ENABLE, 32'h0000_0001);
    scan(1'b0);
    pulse(1'b1, 1'b0);
    scan(1'b1);
    wr(irq_pin_pkg::ADDR_STATUS, 32'h0000_0001);
    settle;
    check_pins(1'b0);
  endtask

  task automatic test_regs;
    wr(irq_pin_pkg::ADDR_PIN_CTRL, 32'hffff_ffff);
    rd(irq_pin_pkg::ADDR_PIN_CTRL);
    chk(rdat, 32'h0000_f800);
    bus_req.wstrb <= 4'h1;
    wr(irq_pin_pkg::ADDR_PIN_CTRL, 32'h0000_0000);
    bus_req.wstrb <= 4'hf;
    rd(irq_pin_pkg::ADDR_PIN_CTRL);
    chk(rdat, 32'h0000_f800);
    wr(8'h04, 32'h0000_ffff);
    chk(resp, irq_pin_pkg::RESP_SLVERR);
  endtask

  // an event in the very cycle of its clear keeps the flag set
  task automatic test_set_wins;
    fork
      wr(irq_pin_pkg::ADDR_STATUS, 32'h0000_0001);
      begin
        repeat (2) @(posedge sys_clk_i);
        write_err <= 1'b1;
        @(posedge sys_clk_i);
        write_err <= 1'b0;
      end
    join
    settle;
    rd(irq_pin_pkg::ADDR_STATUS);
    chk(rdat, 32'h0000_0001);
    wr(irq_pin_pkg::ADDR_STATUS, 32'h0000_0001);
    rd(irq_pin_pkg::ADDR_STATUS);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic test_midrun_reset;
    pulse(1'b1, 1'b0);
    settle;
    chk(irq, 1'b1);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk({a_oe, b_oe, irq}, 3'h0);
    rd(irq_pin_pkg::ADDR_PIN_CTRL);
    chk(rdat, 32'h0000_0000);
    rd(irq_pin_pkg::ADDR_STATUS);
    chk(rdat, 32'h0000_0000);
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    bus_req = '0;
    bus_req.wstrb = 4'hf;
    write_err = 1'b0;
    read_err = 1'b0;
    ctrl = 5'h00;
    failures = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    test_reset;
    test_mask;
    test_table;
    test_set_wins;
    test_regs;
    test_midrun_reset;
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    wrap_up;
  end
endmodule

`default_nettype wire

/* rtl/irq_pin_ctrl.sv */
// Purpose: host interrupt pin stage with AXI4-Lite register access
// Assumes: source events come from logic on sys_clk_i as one-cycle pulses
// Notes:   pin outputs and bus answers are registered; pins lag one cycle
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module irq_pin_ctrl (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire irq_pin_pkg::axil_req_t bus_req_i,
  output var irq_pin_pkg::axil_rsp_t  bus_rsp_o,
  input  wire logic                   write_err_i,
  input  wire logic                   read_err_i,
  output logic                        irq_o,
  output logic                        irq_out_a_o,
  output logic                        irq_out_a_oe_o,
  output logic                        irq_out_b_o,
  output logic                        irq_out_b_oe_o
);

  typedef enum logic [1:0] {SEL_NONE, SEL_STATUS, SEL_ENABLE, SEL_PIN_CTRL} sel_t;

  typedef struct packed {
    logic                                awready;
    logic                                wready;
    logic                                arready;
    logic                                aw_held;
    logic                                w_held;
    logic [irq_pin_pkg::ADDR_W-1:0]      awaddr;
    logic [irq_pin_pkg::DATA_W-1:0]      wdata;
    logic [3:0]                          wstrb;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                rvalid;
    logic [irq_pin_pkg::DATA_W-1:0]      rdata;
    logic [1:0]                          rresp;
    irq_pin_pkg::pin_ctrl_t              pin_ctrl;
    logic [irq_pin_pkg::NUM_SRC-1:0]     enable;
    logic                                irq;
    irq_pin_pkg::pin_t                   pin_a;
    irq_pin_pkg::pin_t                   pin_b;
  } ctrl_state_t;

  ctrl_state_t                     s_reg;
  ctrl_state_t                     s_next;
  logic [irq_pin_pkg::NUM_SRC-1:0] events;
  logic [irq_pin_pkg::NUM_SRC-1:0] clear;
  logic [irq_pin_pkg::NUM_SRC-1:0] status;
  logic                            pending;
  logic [1:0]                      pin_active;
  logic [1:0]                      pin_pol;
  logic [1:0]                      pin_style;
  irq_pin_pkg::pin_t               pin_next [2];

  function automatic sel_t decode(input logic [irq_pin_pkg::ADDR_W-1:0] addr);
    sel_t sel;
    sel = SEL_NONE;
    if (addr == irq_pin_pkg::ADDR_STATUS)
      sel = SEL_STATUS;
    else if (addr == irq_pin_pkg::ADDR_ENABLE)
      sel = SEL_ENABLE;
    else if (addr == irq_pin_pkg::ADDR_PIN_CTRL)
      sel = SEL_PIN_CTRL;
    return sel;
  endfunction

  always_comb
  begin
    events = '0;
    events[irq_pin_pkg::SRC_WRITE_ERR] = write_err_i;
    events[irq_pin_pkg::SRC_READ_ERR]  = read_err_i;
  end

  irq_source_flags u_flags (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .event_i   (events),
    .clear_i   (clear),
    .enable_i  (s_reg.enable),
    .status_o  (status),
    .pending_o (pending)
  );

  // index 0 is pin a, index 1 is pin b
  always_comb
  begin
    pin_active[0] = pending & s_reg.pin_ctrl.gate_a;
    pin_active[1] = pending;
    pin_pol[0]    = s_reg.pin_ctrl.pol_a;
    pin_pol[1]    = s_reg.pin_ctrl.pol_b;
    pin_style[0]  = s_reg.pin_ctrl.style_a;
    pin_style[1]  = s_reg.pin_ctrl.style_b;
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    irq_pin_drive u_drive (
      .active_i (pin_active[g]),
      .pol_i    (pin_pol[g]),
      .style_i  (pin_style[g]),
      .pin_o    (pin_next[g])
    );
  end

  always_comb
  begin
    s_next = s_reg;
    clear  = '0;
    if (s_reg.bvalid && bus_req_i.bready)
      s_next.bvalid = 1'b0;
    if (s_reg.rvalid && bus_req_i.rready)
      s_next.rvalid = 1'b0;
    if (bus_req_i.awvalid && s_reg.awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.awaddr  = bus_req_i.awaddr;
    end
    if (bus_req_i.wvalid && s_reg.wready)
    begin
      s_next.w_held = 1'b1;
      s_next.wdata  = bus_req_i.wdata;
      s_next.wstrb  = bus_req_i.wstrb;
    end
    // write happens once address and data are both held
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = irq_pin_pkg::RESP_OKAY;
      unique case (decode(s_reg.awaddr))
        SEL_STATUS:
          if (s_reg.wstrb[0])
            clear = s_reg.wdata[irq_pin_pkg::NUM_SRC-1:0];
        SEL_ENABLE:
          if (s_reg.wstrb[0])
            s_next.enable = s_reg.wdata[irq_pin_pkg::NUM_SRC-1:0];
        SEL_PIN_CTRL:
          if (s_reg.wstrb[1])
            s_next.pin_ctrl = s_reg.wdata[irq_pin_pkg::CTRL_LSB +: irq_pin_pkg::CTRL_W];
        SEL_NONE:
          s_next.bresp = irq_pin_pkg::RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_held;
    s_next.wready  = !s_next.w_held;
    if (bus_req_i.arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = irq_pin_pkg::RESP_OKAY;
      s_next.rdata  = '0;
      unique case (decode(bus_req_i.araddr))
        SEL_STATUS:
          s_next.rdata[irq_pin_pkg::NUM_SRC-1:0] = status;
        SEL_ENABLE:
          s_next.rdata[irq_pin_pkg::NUM_SRC-1:0] = s_reg.enable;
        SEL_PIN_CTRL:
          s_next.rdata[irq_pin_pkg::CTRL_LSB +: irq_pin_pkg::CTRL_W] = s_reg.pin_ctrl;
        SEL_NONE:
          s_next.rresp = irq_pin_pkg::RESP_SLVERR;
      endcase
    end
    s_next.arready = !s_next.rvalid;
    s_next.irq     = pending;
    s_next.pin_a   = pin_next[0];
    s_next.pin_b   = pin_next[1];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg          <= '0;
      s_reg.awready  <= 1'b1;
      s_reg.wready   <= 1'b1;
      s_reg.arready  <= 1'b1;
      s_reg.pin_ctrl <= irq_pin_pkg::PIN_CTRL_RESET[irq_pin_pkg::CTRL_LSB +: irq_pin_pkg::CTRL_W];
      s_reg.enable   <= irq_pin_pkg::ENABLE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus_rsp_o.awready = s_reg.awready;
  assign bus_rsp_o.wready  = s_reg.wready;
  assign bus_rsp_o.bvalid  = s_reg.bvalid;
  assign bus_rsp_o.bresp   = s_reg.bresp;
  assign bus_rsp_o.arready = s_reg.arready;
  assign bus_rsp_o.rvalid  = s_reg.rvalid;
  assign bus_rsp_o.rdata   = s_reg.rdata;
  assign bus_rsp_o.rresp   = s_reg.rresp;
  assign irq_o             = s_reg.irq;
  assign irq_out_a_o       = s_reg.pin_a.out;
  assign irq_out_a_oe_o    = s_reg.pin_a.oe;
  assign irq_out_b_o       = s_reg.pin_b.out;
  assign irq_out_b_oe_o    = s_reg.pin_b.oe;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  pin_b_float_a : assert property (
    (!s_reg.pin_ctrl.style_b && !s_reg.pin_ctrl.pol_b)
      |=> (irq_out_b_oe_o == $past(pending)) && !(irq_out_b_oe_o && irq_out_b_o))
    else $error("pin b open-drain low polarity wrong");

  pin_b_push_a : assert property (
    (!s_reg.pin_ctrl.style_b && s_reg.pin_ctrl.pol_b)
      |=> irq_out_b_oe_o && (irq_out_b_o == $past(pending)))
    else $error("pin b open-drain high polarity wrong");

  pin_b_driven_a : assert property (
    s_reg.pin_ctrl.style_b
      |=> irq_out_b_oe_o && (irq_out_b_o == ($past(pending) ~^ $past(s_reg.pin_ctrl.pol_b))))
    else $error("pin b not driven in driven style");

  pin_a_polarity_a : assert property (
    (s_reg.pin_ctrl.gate_a && pending)
      |=> irq_out_a_oe_o && (irq_out_a_o == $past(s_reg.pin_ctrl.pol_a)))
    else $error("pin a active level does not follow polarity");

  low_pol_driven_a : assert property (
    (s_reg.pin_ctrl.style_a && s_reg.pin_ctrl.style_b && !s_reg.pin_ctrl.pol_a
      && !s_reg.pin_ctrl.pol_b && !pending)
      |=> irq_out_a_oe_o && irq_out_a_o && irq_out_b_oe_o && irq_out_b_o)
    else $error("driven low-polarity pins not high when idle");

  high_pol_pins_a : assert property (
    (s_reg.pin_ctrl.pol_a && s_reg.pin_ctrl.pol_b && s_reg.pin_ctrl.gate_a)
      |=> irq_out_a_oe_o && irq_out_b_oe_o
        && (irq_out_a_o == $past(pending)) && (irq_out_b_o == $past(pending)))
    else $error("high-polarity pins do not follow pending");

  pin_a_gate_a : assert property (
    (!s_reg.pin_ctrl.gate_a && !s_reg.pin_ctrl.style_a && !s_reg.pin_ctrl.pol_a)[*2]
      |-> !irq_out_a_oe_o)
    else $error("gated pin a left its inactive state");

  irq_follows_a : assert property (
    (status & s_reg.enable) != '0 |=> irq_o)
    else $error("unmasked status did not raise the interrupt output");

  irq_idle_a : assert property (
    ((status & s_reg.enable) == '0) |=> !irq_o)
    else $error("interrupt output high with no unmasked status");

  pin_a_idle_a : assert property (
    (s_reg.pin_ctrl.gate_a && s_reg.pin_ctrl.pol_a && !pending)
      |=> irq_out_a_oe_o && !irq_out_a_o)
    else $error("high-polarity pin a not low when idle");

  pin_a_inactive_a : assert property (
    (!s_reg.pin_ctrl.gate_a && (s_reg.pin_ctrl.style_a || s_reg.pin_ctrl.pol_a))
      |=> irq_out_a_oe_o && (irq_out_a_o != $past(s_reg.pin_ctrl.pol_a)))
    else $error("gated pin a not held at its inactive level");

  low_pol_pending_a : assert property (
    (s_reg.pin_ctrl.style_a && s_reg.pin_ctrl.style_b && !s_reg.pin_ctrl.pol_a
      && !s_reg.pin_ctrl.pol_b && s_reg.pin_ctrl.gate_a && pending)
      |=> irq_out_a_oe_o && !irq_out_a_o && irq_out_b_oe_o && !irq_out_b_o)
    else $error("driven low-polarity pins not low when pending");

  pin_b_ungated_a : assert property (
    (pending && s_reg.pin_ctrl.pol_b) |=> irq_out_b_oe_o && irq_out_b_o)
    else $error("pin b high-polarity request not driven high");

  // bus answers stand until the master takes them
  bvalid_hold_a : assert property (
    (bus_rsp_o.bvalid && !bus_req_i.bready) |=> bus_rsp_o.bvalid && $stable(bus_rsp_o.bresp))
    else $error("write response dropped before it was taken");

  rvalid_hold_a : assert property (
    (bus_rsp_o.rvalid && !bus_req_i.rready) |=> bus_rsp_o.rvalid && $stable(bus_rsp_o.rdata))
    else $error("read response dropped before it was taken");

  aw_taken_a : assert property (
    (bus_req_i.awvalid && bus_rsp_o.awready) |=> !bus_rsp_o.awready)
    else $error("write address not held after it was taken");

  read_answer_a : assert property (
    (bus_req_i.arvalid && bus_rsp_o.arready) |=> bus_rsp_o.rvalid)
    else $error("accepted read got no answer");

  write_answer_a : assert property (
    (!bus_rsp_o.awready && !bus_rsp_o.wready && !bus_rsp_o.bvalid) |=> bus_rsp_o.bvalid)
    else $error("held write got no answer");

  read_refused_a : assert property (
    bus_rsp_o.rvalid |-> !bus_rsp_o.arready)
    else $error("read address accepted while a read answer stands");

endmodule

`default_nettype wire

/* rtl/irq_pin_drive.sv */
// Purpose: output stage of one interrupt request pin
// Assumes: active_i is the request this pin should signal
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none

module irq_pin_drive (
  input  wire logic            active_i,
  input  wire logic            pol_i,
  input  wire logic            style_i,
  output var irq_pin_pkg::pin_t pin_o
);

  always_comb
  begin
    // active level is high when pol_i is set, low otherwise
    pin_o.out = active_i ~^ pol_i;
    // float only in the open-drain style, active-low polarity, while idle
    pin_o.oe  = style_i | pol_i | active_i;
  end

endmodule

`default_nettype wire

/* rtl/irq_pin_pkg.sv */
// Purpose: shared constants and carrier types of the host interrupt pin stage
// Assumes: 32-bit AXI4-Lite register access, byte address = 4 * register index
// Notes:   pin control fields occupy bits 15..11 of a 16-bit register
package irq_pin_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SRC = 2;

  // register indices; the byte address is four times the index
  localparam int unsigned IDX_STATUS   = 32'h26;
  localparam int unsigned IDX_ENABLE   = 32'h28;
  localparam int unsigned IDX_PIN_CTRL = 32'h2a;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_ENABLE   = ADDR_W'(IDX_ENABLE * 4);
  localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL = ADDR_W'(IDX_PIN_CTRL * 4);

  // interrupt source positions in status and enable
  localparam int unsigned SRC_WRITE_ERR = 0;
  localparam int unsigned SRC_READ_ERR  = 1;

  // pin control field positions
  localparam int unsigned GATE_A_BIT  = 15;
  localparam int unsigned STYLE_B_BIT = 14;
  localparam int unsigned STYLE_A_BIT = 13;
  localparam int unsigned POL_B_BIT   = 12;
  localparam int unsigned POL_A_BIT   = 11;
  localparam int unsigned CTRL_LSB    = POL_A_BIT;
  localparam int unsigned CTRL_W      = 5;

  localparam logic [15:0]        PIN_CTRL_RESET = 16'h0000;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET   = 2'h0;
  localparam logic [NUM_SRC-1:0] STATUS_RESET   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axil_rsp_t;

  // same order as bits 15..11 of the pin control register
  typedef struct packed {
    logic gate_a;
    logic style_b;
    logic style_a;
    logic pol_b;
    logic pol_a;
  } pin_ctrl_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

endpackage

/* rtl/irq_source_flags.sv */
// Purpose: sticky status flags of the interrupt sources and the pending term
// Assumes: events and clears are one-cycle pulses on sys_clk_i
// Notes:   an event in the clear cycle keeps its flag set
`timescale 1ns/10ps
`default_nettype none

module irq_source_flags (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [irq_pin_pkg::NUM_SRC-1:0] event_i,
  input  wire logic [irq_pin_pkg::NUM_SRC-1:0] clear_i,
  input  wire logic [irq_pin_pkg::NUM_SRC-1:0] enable_i,
  output logic      [irq_pin_pkg::NUM_SRC-1:0] status_o,
  output logic                               pending_o
);

  typedef struct packed {
    logic [irq_pin_pkg::NUM_SRC-1:0] status;
  } flags_state_t;

  flags_state_t s_reg;
  flags_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    // flag records the event whatever its enable holds
    s_next.status = (s_reg.status & ~clear_i) | event_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg.status <= irq_pin_pkg::STATUS_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign status_o  = s_reg.status;
  assign pending_o = |(s_reg.status & enable_i);

  flag_set_wins_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (event_i != '0) |=> ((status_o & $past(event_i)) == $past(event_i)))
    else $error("event did not set its status flag");

  pending_gated_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ((status_o & enable_i) == '0) |-> !pending_o)
    else $error("disabled source raised the pending term");

endmodule

`default_nettype wire
